// file: logic/dsa_pkg.sv
// Constants shared by the section adaptation block.
// Assumes a four-tone symbol with one sample of cyclic prefix.
package dsa_pkg;
    localparam int SAMPLE_W = 12;
    localparam int FRAME_W = 16;
    localparam int TONE0_BITS = 2;
    localparam int TONE1_BITS = 2;
    localparam int TONE2_BITS = 4;
    localparam int TONE3_BITS = 8;
    localparam int TF_SHIFT = 2;
    localparam logic [6:0] SF_LAST = 7'h44;
    localparam logic [2:0] SYM_LAST = 3'h4;
    localparam logic [15:0] SYNC_WORD = 16'hB4E1;
    localparam logic [15:0] IDLE_WORD = 16'h0000;
    localparam logic [1:0] BUF_DEPTH = 2'h2;
    localparam logic [4:0] BITS_FULL = 5'h10;
    typedef enum logic {ALN_HUNT, ALN_LOCK} dsa_aln_type;
    typedef enum logic {SF_HUNT, SF_LOCK} dsa_sf_type;
endpackage : dsa_pkg

// file: logic/dsa_section_adapt.sv
// Section to line-sample adaptation, transmit and receive directions.
// Assumes the line sample clock arrives from the converter and is far
// slower than i_ref_clk; frame words arrive on the i_ref_clk domain.
`timescale 1ns/10ps
`default_nettype none
module dsa_section_adapt
    import dsa_pkg::*;
(
    input wire logic i_ref_clk, // system clock
    input wire logic i_rst, // synchronous reset
    input wire logic [15:0] i_tx_frame_data, // fast and interleaved byte
    input wire logic i_tx_frame_valid, // frame word offered
    output logic o_tx_frame_ready, // buffer can take a word
    output logic [11:0] o_line_sample_data, // transmit sample
    input wire logic i_line_sample_clock, // converter sample clock
    input wire logic [11:0] i_line_sample_data, // receive sample
    input wire logic i_line_trail_fail_in, // converter trail fail
    input wire logic [3:0] i_lof_tone_mask, // tones used for sync check
    input wire logic [2:0] i_lof_threshold, // least matching tones
    output logic o_section_frame_data, // receive frame bit
    output logic o_section_bit_clock, // bit strobe
    output logic o_section_frame_clock, // first bit of frame
    output logic o_section_superframe_clock, // first bit of superframe
    output logic o_section_server_fail_out, // server signal fail
    output logic o_remote_defect_request, // remote defect request
    output logic o_frame_loss_remote_report, // frame loss to far end
    output logic o_frame_loss_mgmt_report // correlated frame loss
);

    function automatic logic [11:0] enc(input logic [7:0] b,
                                        input int nb);
        return 12'(int'(b & 8'((1 << nb) - 1)) - (1 << (nb - 1)));
    endfunction : enc

    function automatic logic [7:0] dec(input logic [11:0] v,
                                       input int nb);
        return 8'((int'(signed'(v)) + (1 << (nb - 1))) & ((1 << nb) - 1));
    endfunction : dec

    // Four-point orthogonal transform; applying it twice scales by four.
    function automatic logic [47:0] xform(input logic [47:0] x,
                                          input int sh);
        int a;
        int b;
        int c;
        int d;
        a = int'(signed'(x[11:0]));
        b = int'(signed'(x[23:12]));
        c = int'(signed'(x[35:24]));
        d = int'(signed'(x[47:36]));
        return {12'((a - b - c + d) >>> sh),
                12'((a + b - c - d) >>> sh),
                12'((a - b + c - d) >>> sh),
                12'((a + b + c + d) >>> sh)};
    endfunction : xform

    // Tone 0 sits in the low bits of the returned vector.
    function automatic logic [47:0] tones(input logic [15:0] w);
        return {enc(w[7:0], TONE3_BITS),
                enc({4'h0, w[15:12]}, TONE2_BITS),
                enc({6'h00, w[11:10]}, TONE1_BITS),
                enc({6'h00, w[9:8]}, TONE0_BITS)};
    endfunction : tones

    function automatic logic [7:0] swap(input logic [7:0] b);
        return {b[3:0], b[7:4]};
    endfunction : swap

    logic clk_s1_r;
    logic clk_s2_r;
    logic clk_s3_r;
    logic [11:0] din_s1_r;
    logic [11:0] din_s2_r;
    logic tsf_s1_r;
    logic tsf_s2_r;
    logic samp_en;

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            clk_s1_r <= 1'b0;
            clk_s2_r <= 1'b0;
            clk_s3_r <= 1'b0;
            din_s1_r <= 12'h000;
            din_s2_r <= 12'h000;
            tsf_s1_r <= 1'b0;
            tsf_s2_r <= 1'b0;
        end else begin
            clk_s1_r <= i_line_sample_clock;
            clk_s2_r <= clk_s1_r;
            clk_s3_r <= clk_s2_r;
            din_s1_r <= i_line_sample_data;
            din_s2_r <= din_s1_r;
            tsf_s1_r <= i_line_trail_fail_in;
            tsf_s2_r <= tsf_s1_r;
        end
    end

    assign samp_en = clk_s2_r & ~clk_s3_r;

    // Two-entry frame buffer in front of the transmit symbol builder.
    logic [15:0] b0_r;
    logic [15:0] b0_nxt;
    logic [15:0] b1_r;
    logic [15:0] b1_nxt;
    logic [1:0] cnt_r;
    logic [1:0] cnt_nxt;
    logic rdy_r;
    logic rdy_nxt;
    logic push;
    logic tx_pop;

    always_comb begin
        push = i_tx_frame_valid & rdy_r;
        b0_nxt = b0_r;
        b1_nxt = b1_r;
        if (tx_pop) begin
            b0_nxt = b1_r;
        end
        if (push) begin
            if (cnt_r == {1'b0, tx_pop}) begin
                b0_nxt = i_tx_frame_data;
            end else begin
                b1_nxt = i_tx_frame_data;
            end
        end
        cnt_nxt = 2'(cnt_r + {1'b0, push} - {1'b0, tx_pop});
        rdy_nxt = cnt_nxt != BUF_DEPTH;
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            b0_r <= IDLE_WORD;
            b1_r <= IDLE_WORD;
            cnt_r <= 2'h0;
            rdy_r <= 1'b1;
        end else begin
            b0_r <= b0_nxt;
            b1_r <= b1_nxt;
            cnt_r <= cnt_nxt;
            rdy_r <= rdy_nxt;
        end
    end

    assign o_tx_frame_ready = rdy_r;

    // Transmit: one symbol is prefix plus four samples.
    logic [2:0] tx_pos_r;
    logic [2:0] tx_pos_nxt;
    logic [6:0] tx_fcnt_r;
    logic [6:0] tx_fcnt_nxt;
    logic [47:0] tx_sym_r;
    logic [47:0] tx_sym_nxt;
    logic [11:0] tx_out_r;
    logic [11:0] tx_out_nxt;
    logic [15:0] src;

    always_comb begin
        tx_pop = 1'b0;
        tx_pos_nxt = tx_pos_r;
        tx_fcnt_nxt = tx_fcnt_r;
        tx_sym_nxt = tx_sym_r;
        tx_out_nxt = tx_out_r;
        src = (cnt_r != 2'h0) ? b0_r : IDLE_WORD;
        if (samp_en) begin
            if (tx_pos_r == 3'h0) begin
                if (tx_fcnt_r == SF_LAST) begin
                    tx_sym_nxt = xform(tones(SYNC_WORD), 0);
                    tx_fcnt_nxt = 7'h00;
                end else begin
                    tx_pop = cnt_r != 2'h0;
                    tx_sym_nxt = xform(tones({src[15:8],
                                              swap(src[7:0])}), 0);
                    tx_fcnt_nxt = 7'(tx_fcnt_r + 7'h01);
                end
                tx_out_nxt = tx_sym_nxt[47:36];
                tx_pos_nxt = 3'h1;
            end else begin
                tx_out_nxt = tx_sym_r[12 * (int'(tx_pos_r) - 1) +: 12];
                tx_pos_nxt = (tx_pos_r == SYM_LAST) ? 3'h0
                                                    : 3'(tx_pos_r + 3'h1);
            end
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            tx_pos_r <= 3'h0;
            tx_fcnt_r <= 7'h00;
            tx_sym_r <= 48'h000000000000;
            tx_out_r <= 12'h000;
        end else begin
            tx_pos_r <= tx_pos_nxt;
            tx_fcnt_r <= tx_fcnt_nxt;
            tx_sym_r <= tx_sym_nxt;
            tx_out_r <= tx_out_nxt;
        end
    end

    assign o_line_sample_data = tx_out_r;

    // Receive symbol alignment on the cyclic prefix.
    dsa_aln_type aln_r;
    dsa_aln_type aln_nxt;
    logic [59:0] win_r;
    logic [59:0] win_nxt;
    logic [2:0] rcnt_r;
    logic [2:0] rcnt_nxt;
    logic done_r;
    logic done_nxt;
    logic cp_ok;

    always_comb begin
        aln_nxt = aln_r;
        win_nxt = win_r;
        rcnt_nxt = rcnt_r;
        done_nxt = 1'b0;
        cp_ok = win_r[47:36] == din_s2_r;
        if (samp_en) begin
            win_nxt = {win_r[47:0], din_s2_r};
            case (aln_r)
                ALN_HUNT: begin
                    if (cp_ok) begin
                        aln_nxt = ALN_LOCK;
                        rcnt_nxt = 3'h0;
                        done_nxt = 1'b1;
                    end
                end
                default: begin
                    if (rcnt_r == SYM_LAST) begin
                        rcnt_nxt = 3'h0;
                        if (cp_ok) begin
                            done_nxt = 1'b1;
                        end else begin
                            aln_nxt = ALN_HUNT;
                        end
                    end else begin
                        rcnt_nxt = 3'(rcnt_r + 3'h1);
                    end
                end
            endcase
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            aln_r <= ALN_HUNT;
            win_r <= 60'h000000000000000;
            rcnt_r <= 3'h0;
            done_r <= 1'b0;
        end else begin
            aln_r <= aln_nxt;
            win_r <= win_nxt;
            rcnt_r <= rcnt_nxt;
            done_r <= done_nxt;
        end
    end

    // Decode; the prefix sample win_r[59:48] is dropped.
    logic [47:0] ry;
    logic [15:0] rw;
    logic [2:0] hits;
    logic matched;

    always_comb begin
        ry = xform({win_r[11:0], win_r[23:12], win_r[35:24],
                    win_r[47:36]}, TF_SHIFT);
        rw = {4'(dec(ry[35:24], TONE2_BITS)),
              2'(dec(ry[23:12], TONE1_BITS)),
              2'(dec(ry[11:0], TONE0_BITS)),
              dec(ry[47:36], TONE3_BITS)};
        hits = 3'({2'h0, i_lof_tone_mask[0] & (rw[9:8] == SYNC_WORD[9:8])}
             + {2'h0, i_lof_tone_mask[1] & (rw[11:10] == SYNC_WORD[11:10])}
             + {2'h0, i_lof_tone_mask[2] & (rw[15:12] == SYNC_WORD[15:12])}
             + {2'h0, i_lof_tone_mask[3] & (rw[7:0] == SYNC_WORD[7:0])});
        matched = hits >= i_lof_threshold;
    end

    // Superframe lock, frame loss and the section-side serializer.
    dsa_sf_type sf_r;
    dsa_sf_type sf_nxt;
    logic [6:0] rf_r;
    logic [6:0] rf_nxt;
    logic ok_r;
    logic ok_nxt;
    logic lof_r;
    logic lof_nxt;
    logic pend_r;
    logic pend_nxt;
    logic [15:0] sh_r;
    logic [15:0] sh_nxt;
    logic [4:0] nb_r;
    logic [4:0] nb_nxt;
    logic sff_r;
    logic sff_nxt;
    logic ph_r;
    logic dat_r;
    logic dat_nxt;
    logic bclk_r;
    logic bclk_nxt;
    logic fclk_r;
    logic fclk_nxt;
    logic sclk_r;
    logic sclk_nxt;

    always_comb begin
        sf_nxt = sf_r;
        rf_nxt = rf_r;
        ok_nxt = ok_r;
        lof_nxt = lof_r;
        pend_nxt = pend_r;
        sh_nxt = sh_r;
        nb_nxt = nb_r;
        sff_nxt = sff_r;
        dat_nxt = dat_r;
        bclk_nxt = 1'b0;
        fclk_nxt = 1'b0;
        sclk_nxt = 1'b0;
        if (ph_r && nb_r != 5'h00) begin
            dat_nxt = sh_r[15];
            bclk_nxt = 1'b1;
            fclk_nxt = nb_r == BITS_FULL;
            sclk_nxt = (nb_r == BITS_FULL) & sff_r;
            sh_nxt = {sh_r[14:0], 1'b0};
            nb_nxt = 5'(nb_r - 5'h01);
        end
        if (done_r) begin
            case (sf_r)
                SF_HUNT: begin
                    if (matched) begin
                        sf_nxt = SF_LOCK;
                        rf_nxt = 7'h00;
                        pend_nxt = 1'b1;
                        ok_nxt = 1'b1;
                    end
                end
                default: begin
                    if (rf_r == SF_LAST) begin
                        rf_nxt = 7'h00;
                        pend_nxt = 1'b1;
                        ok_nxt = matched;
                        if (matched && ok_r) begin
                            lof_nxt = 1'b0;
                        end
                        if (!matched && !ok_r) begin
                            lof_nxt = 1'b1;
                            sf_nxt = SF_HUNT;
                        end
                    end else begin
                        sh_nxt = {rw[15:8], swap(rw[7:0])};
                        nb_nxt = BITS_FULL;
                        sff_nxt = pend_r;
                        pend_nxt = 1'b0;
                        rf_nxt = 7'(rf_r + 7'h01);
                    end
                end
            endcase
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            sf_r <= SF_HUNT;
            rf_r <= 7'h00;
            ok_r <= 1'b0;
            lof_r <= 1'b1;
            pend_r <= 1'b0;
            sh_r <= 16'h0000;
            nb_r <= 5'h00;
            sff_r <= 1'b0;
            ph_r <= 1'b0;
            dat_r <= 1'b0;
            bclk_r <= 1'b0;
            fclk_r <= 1'b0;
            sclk_r <= 1'b0;
        end else begin
            sf_r <= sf_nxt;
            rf_r <= rf_nxt;
            ok_r <= ok_nxt;
            lof_r <= lof_nxt;
            pend_r <= pend_nxt;
            sh_r <= sh_nxt;
            nb_r <= nb_nxt;
            sff_r <= sff_nxt;
            ph_r <= ~ph_r;
            dat_r <= dat_nxt;
            bclk_r <= bclk_nxt;
            fclk_r <= fclk_nxt;
            sclk_r <= sclk_nxt;
        end
    end

    assign o_section_frame_data = dat_r;
    assign o_section_bit_clock = bclk_r;
    assign o_section_frame_clock = fclk_r;
    assign o_section_superframe_clock = sclk_r;

    // Consequent actions; trail fail comes via its synchroniser.
    logic ssf_r;
    logic rdi_r;
    logic mgmt_r;

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            ssf_r <= 1'b1;
            rdi_r <= 1'b1;
            mgmt_r <= 1'b0;
        end else begin
            ssf_r <= lof_r | tsf_s2_r;
            rdi_r <= lof_r | tsf_s2_r;
            mgmt_r <= lof_r & ~tsf_s2_r;
        end
    end

    assign o_section_server_fail_out = ssf_r;
    assign o_remote_defect_request = rdi_r;
    assign o_frame_loss_remote_report = rdi_r;
    assign o_frame_loss_mgmt_report = mgmt_r;

endmodule : dsa_section_adapt
`default_nettype wire

// file: tb/dsa_line_model.sv
// Converter model for the line sample side of the adaptation block.
// Assumes the transmit samples are looped back as receive samples.
`timescale 1ns/10ps
`default_nettype none
module dsa_line_model (
    input wire logic [11:0] i_tx_sample, // sample from the block
    input wire logic i_offset_en, // shift tone zero by one step
    input wire logic i_signal_lost, // bench asks for signal loss
    output logic o_sample_clock, // converter sample clock
    output logic [11:0] o_rx_sample, // sample back to the block
    output logic o_trail_fail // converter trail fail
);
    logic [11:0] held;
    initial begin
        held = 12'h000;
        o_rx_sample = 12'h000;
        o_sample_clock = 1'b0;
        #7;
        forever #80 o_sample_clock = ~o_sample_clock;
    end
    // Capture on the rise and present on the fall, away from both changes.
    always @(posedge o_sample_clock) held <= i_tx_sample;
    always @(negedge o_sample_clock) begin
        o_rx_sample <= held + (i_offset_en ? 12'h001 : 12'h000);
    end
    assign o_trail_fail = i_signal_lost;
endmodule : dsa_line_model
`default_nettype wire

// file: tb/dsa_section_adapt_checker.sv
// Port-level assertions for the section adaptation block.
// Assumes it is bound to the block's top module.
`timescale 1ns/10ps
`default_nettype none
module dsa_section_adapt_checker (
    input wire logic i_ref_clk, // system clock
    input wire logic i_rst, // synchronous reset
    input wire logic i_tx_frame_valid, // frame word offered
    input wire logic o_tx_frame_ready, // buffer can take a word
    input wire logic [11:0] o_line_sample_data, // transmit sample
    input wire logic i_line_trail_fail_in, // converter trail fail
    input wire logic o_section_bit_clock, // bit strobe
    input wire logic o_section_frame_clock, // first bit of frame
    input wire logic o_section_superframe_clock, // first superframe bit
    input wire logic o_section_server_fail_out, // server signal fail
    input wire logic o_remote_defect_request, // remote defect request
    input wire logic o_frame_loss_remote_report, // remote frame loss
    input wire logic o_frame_loss_mgmt_report // correlated frame loss
);
    logic [4:0] bit_cnt_r;
    logic [4:0] bit_cnt_nxt;
    always_comb begin
        bit_cnt_nxt = bit_cnt_r;
        if (o_section_bit_clock) begin
            bit_cnt_nxt = o_section_frame_clock ? 5'h01 : bit_cnt_r + 5'h01;
        end
    end
    always_ff @(posedge i_ref_clk) begin
        bit_cnt_r <= i_rst ? 5'h00 : bit_cnt_nxt;
    end
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    sequence trail_held;
        i_line_trail_fail_in [*4];
    endsequence
    sequence fail_shown;
        o_section_server_fail_out && !o_frame_loss_mgmt_report;
    endsequence
    chk_trail_fail: assert property (trail_held |=> fail_shown)
        else $error("trail fail not shown as server fail");
    chk_rdi_same: assert property (
        o_remote_defect_request == o_section_server_fail_out)
        else $error("remote defect differs from server fail");
    chk_remote_lof: assert property (
        o_frame_loss_remote_report == o_remote_defect_request)
        else $error("remote report differs from remote defect");
    chk_mgmt_cause: assert property (
        o_frame_loss_mgmt_report |-> o_section_server_fail_out)
        else $error("management report without frame loss");
    chk_bit_pulse: assert property (
        o_section_bit_clock |=> !o_section_bit_clock)
        else $error("bit strobe longer than one cycle");
    chk_frame_first: assert property (
        o_section_frame_clock |-> o_section_bit_clock)
        else $error("frame strobe without bit strobe");
    chk_sf_frame: assert property (
        o_section_superframe_clock |-> o_section_frame_clock)
        else $error("superframe strobe without frame strobe");
    chk_frame_len: assert property (o_section_frame_clock |->
        (bit_cnt_r == 5'h00 || bit_cnt_r == 5'h10))
        else $error("frame not sixteen bits long");
    chk_ready_fall: assert property (
        $fell(o_tx_frame_ready) |-> $past(i_tx_frame_valid))
        else $error("buffer full without words offered");
    chk_ready_back: assert property (
        $fell(o_tx_frame_ready) |-> ##[1:100] o_tx_frame_ready)
        else $error("buffer never drained");
    chk_sample_hold: assert property (
        $changed(o_line_sample_data) |=> $stable(o_line_sample_data) [*4])
        else $error("transmit sample changed too soon");
endmodule : dsa_section_adapt_checker
bind dsa_section_adapt dsa_section_adapt_checker u_chk (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_tx_frame_valid(i_tx_frame_valid),
    .o_tx_frame_ready(o_tx_frame_ready),
    .o_line_sample_data(o_line_sample_data),
    .i_line_trail_fail_in(i_line_trail_fail_in),
    .o_section_bit_clock(o_section_bit_clock),
    .o_section_frame_clock(o_section_frame_clock),
    .o_section_superframe_clock(o_section_superframe_clock),
    .o_section_server_fail_out(o_section_server_fail_out),
    .o_remote_defect_request(o_remote_defect_request),
    .o_frame_loss_remote_report(o_frame_loss_remote_report),
    .o_frame_loss_mgmt_report(o_frame_loss_mgmt_report)
);
`default_nettype wire

// file: tb/dsa_section_adapt_tb.sv
// Self-checking bench for the section adaptation block.
// Assumes the line model loops transmit samples back to the receiver.
`timescale 1ns/10ps
`default_nettype none
module dsa_section_adapt_tb;
    logic i_ref_clk, i_rst, i_tx_frame_valid, trail, offset;
    logic [7:0] tx_n;
    logic [15:0] i_tx_frame_data;
    logic [3:0] mask;
    logic [2:0] thr;
    logic o_tx_frame_ready, i_line_sample_clock, i_line_trail_fail_in;
    logic [11:0] o_line_sample_data, i_line_sample_data;
    logic o_section_frame_data, o_section_bit_clock, o_section_frame_clock;
    logic o_section_superframe_clock, o_section_server_fail_out;
    logic o_remote_defect_request, o_frame_loss_remote_report;
    logic o_frame_loss_mgmt_report;
    logic [15:0] rx_sh, rx_word;
    logic [4:0] rx_bits;
    logic [7:0] sf_gap, sf_last;
    int rx_frames, err_total, n_compared;
    // Each word carries its index and a check byte for the receive side.
    assign i_tx_frame_data = {tx_n, tx_n ^ 8'h5A};
    dsa_section_adapt dut (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_tx_frame_data(i_tx_frame_data),
        .i_tx_frame_valid(i_tx_frame_valid),
        .o_tx_frame_ready(o_tx_frame_ready),
        .o_line_sample_data(o_line_sample_data),
        .i_line_sample_clock(i_line_sample_clock),
        .i_line_sample_data(i_line_sample_data),
        .i_line_trail_fail_in(i_line_trail_fail_in),
        .i_lof_tone_mask(mask),
        .i_lof_threshold(thr),
        .o_section_frame_data(o_section_frame_data),
        .o_section_bit_clock(o_section_bit_clock),
        .o_section_frame_clock(o_section_frame_clock),
        .o_section_superframe_clock(o_section_superframe_clock),
        .o_section_server_fail_out(o_section_server_fail_out),
        .o_remote_defect_request(o_remote_defect_request),
        .o_frame_loss_remote_report(o_frame_loss_remote_report),
        .o_frame_loss_mgmt_report(o_frame_loss_mgmt_report)
    );
    dsa_line_model model (
        .i_tx_sample(o_line_sample_data),
        .i_offset_en(offset),
        .i_signal_lost(trail),
        .o_sample_clock(i_line_sample_clock),
        .o_rx_sample(i_line_sample_data),
        .o_trail_fail(i_line_trail_fail_in)
    );
    initial begin
        i_ref_clk = 1'b0;
        forever #10 i_ref_clk = ~i_ref_clk;
    end
    always @(posedge i_ref_clk) begin
        if (i_tx_frame_valid === 1'b1 && o_tx_frame_ready === 1'b1) begin
            tx_n <= #1 tx_n + 8'h01;
        end
    end
    always @(posedge i_ref_clk) begin
        if (o_section_bit_clock === 1'b1) begin
            rx_sh = {rx_sh[14:0], o_section_frame_data};
            rx_bits = o_section_frame_clock ? 5'h01 : rx_bits + 5'h01;
            if (o_section_superframe_clock === 1'b1) begin
                sf_last = sf_gap;
                sf_gap = 8'h00;
            end
            if (o_section_frame_clock === 1'b1) sf_gap = sf_gap + 8'h01;
            if (rx_bits == 5'h10) begin
                rx_word = rx_sh;
                rx_frames++;
            end
        end
    end
    task automatic results;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : results
    task automatic tick(input int n);
        repeat (n) @(posedge i_ref_clk);
        #1;
    endtask : tick
    task automatic cmp_bit(input logic got, input logic exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_bit
    task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_byte
    task automatic wait_out(input logic sel_rdy, input logic val,
                            input int bound);
        int k;
        k = 0;
        while (((sel_rdy ? o_tx_frame_ready : o_section_server_fail_out)
                !== val) && k < bound) begin
            tick(1);
            k++;
        end
        if (k >= bound) begin
            err_total++;
            results();
        end
    endtask : wait_out
    task automatic wait_frame(input int bound);
        int k;
        int f;
        k = 0;
        f = rx_frames;
        while (rx_frames == f && k < bound) begin
            tick(1);
            k++;
        end
        if (k >= bound) begin
            err_total++;
            results();
        end
    endtask : wait_frame
    task automatic t_buffer;
        i_tx_frame_valid = 1'b1;
        wait_out(1'b1, 1'b0, 8);
        i_tx_frame_valid = 1'b0;
        tick(100);
        cmp_bit(o_tx_frame_ready, 1'b1);
        i_tx_frame_valid = 1'b1;
    endtask : t_buffer
    task automatic t_data;
        int c;
        logic [7:0] prev;
        wait_out(1'b0, 1'b0, 9000);
        cmp_bit(o_frame_loss_mgmt_report, 1'b0);
        wait_frame(200);
        prev = rx_word[15:8];
        for (c = 0; c < 70; c++) begin
            wait_frame(200);
            cmp_byte(rx_word[7:0], rx_word[15:8] ^ 8'h5A);
            cmp_byte(rx_word[15:8], prev + 8'h01);
            prev = rx_word[15:8];
        end
        cmp_byte(sf_last, 8'h44);
    endtask : t_data
    task automatic t_trail;
        trail = 1'b1;
        tick(6);
        cmp_bit(o_section_server_fail_out, 1'b1);
        cmp_bit(o_remote_defect_request, 1'b1);
        cmp_bit(o_frame_loss_mgmt_report, 1'b0);
        trail = 1'b0;
        tick(6);
        cmp_bit(o_section_server_fail_out, 1'b0);
    endtask : t_trail
    task automatic t_loss;
        offset = 1'b1;
        wait_out(1'b0, 1'b1, 9000);
        tick(1);
        cmp_bit(o_frame_loss_mgmt_report, 1'b1);
        trail = 1'b1;
        tick(6);
        cmp_bit(o_frame_loss_mgmt_report, 1'b0);
        cmp_bit(o_frame_loss_remote_report, 1'b1);
        trail = 1'b0;
        offset = 1'b0;
        wait_out(1'b0, 1'b0, 9000);
        cmp_bit(o_remote_defect_request, 1'b0);
        cmp_bit(o_frame_loss_remote_report, 1'b0);
    endtask : t_loss
    task automatic t_subset;
        mask = 4'h0;
        thr = 3'h0;
        offset = 1'b1;
        tick(6000);
        cmp_bit(o_section_server_fail_out, 1'b0);
        offset = 1'b0;
        mask = 4'hF;
        thr = 3'h4;
    endtask : t_subset
    initial begin
        i_rst = 1'b1;
        i_tx_frame_valid = 1'b0;
        trail = 1'b0;
        offset = 1'b0;
        tx_n = 8'h00;
        mask = 4'hF;
        thr = 3'h4;
        rx_sh = 16'h0000;
        rx_word = 16'h0000;
        rx_bits = 5'h00;
        sf_gap = 8'h00;
        sf_last = 8'h00;
        rx_frames = 0;
        err_total = 0;
        n_compared = 0;
        tick(6);
        cmp_bit(o_tx_frame_ready, 1'b1);
        cmp_bit(o_section_server_fail_out, 1'b1);
        cmp_bit(o_frame_loss_mgmt_report, 1'b0);
        i_rst = 1'b0;
        tick(4);
        cmp_bit(o_frame_loss_mgmt_report, 1'b1);
        t_buffer();
        t_data();
        t_trail();
        t_loss();
        t_subset();
        results();
    end
endmodule : dsa_section_adapt_tb
`default_nettype wire
